//--- rtl/bpgc_pkg.sv
/*
 * Constants and carrier types for the board pin glue block: I/O ports,
 * configuration index numbers, field positions, mode codes and reset values.
 * Assumes an ISA-style I/O bus whose inputs are synchronous to the block clock.
 */
package bpgc_pkg;

    // ************************************************************
    // I/O ports of the configuration index/data pair and the latch.
    // ************************************************************
    localparam logic [15:0] CFG_INDEX_PORT = 16'h0022;
    localparam logic [15:0] CFG_DATA_PORT  = 16'h0023;
    localparam logic [15:0] LATCH_PORT     = 16'h0100;

    // ************************************************************
    // Configuration index numbers.
    // ************************************************************
    localparam logic [7:0] IDX_OE_A        = 8'h70;
    localparam logic [7:0] IDX_OE_B        = 8'h74;
    localparam logic [7:0] IDX_SERIAL      = 8'h80;
    localparam logic [7:0] IDX_SERIAL_OVR  = 8'h81;
    localparam logic [7:0] IDX_STROBE_ADDR = 8'h89;
    localparam logic [7:0] IDX_GP_MODE     = 8'h91;
    localparam logic [7:0] IDX_GP_LEVEL    = 8'h92;
    localparam logic [7:0] IDX_CS1_ADDR    = 8'h94;
    localparam logic [7:0] IDX_SPARE_ADDR  = 8'h98;
    localparam logic [7:0] IDX_CS0_ADDR    = 8'h9C;
    localparam logic [7:0] IDX_PM_SLOT1    = 8'hAA;
    localparam logic [7:0] IDX_PM_SLOT2    = 8'hAB;
    localparam logic [7:0] IDX_PM_KBD      = 8'hAC;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int OE_BIT_STROBE = 6;
    localparam int OE_BIT_CS0    = 2;
    localparam int OE_BIT_CS1    = 3;
    localparam int OE_BIT_SPARE  = 4;
    localparam int NIB_LO        = 0;
    localparam int NIB_HI        = 4;
    localparam int OVR_EN_BIT    = 0;
    localparam int OVR_VAL_BIT   = 1;
    localparam int LATCH_ROM_BIT = 2;
    localparam int LATCH_S2_BIT  = 1;
    localparam int LATCH_S1_BIT  = 0;
    localparam int LATCH_W       = 3;
    localparam int NUM_GP        = 4;
    localparam int NUM_PM        = 5;
    localparam int BLK_SHIFT     = 3;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [2:0] LATCH_RESET = 3'h0;

    // ************************************************************
    // Pin modes and carriers.
    // ************************************************************
    typedef enum logic [1:0] {
        GP_PLAIN_IO = 2'b00,
        GP_DEC_IOR  = 2'b01,
        GP_DEC_IOW  = 2'b10,
        GP_DECODE   = 2'b11
    } bpgc_gp_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        iow;
        logic        ior;
    } bpgc_io_bus_t;

    typedef struct packed {
        logic kbd_reset;
        logic slot1_vcc;
        logic slot2_vcc;
        logic rs232_enable;
        logic ir_select;
        logic port2_tx_enable;
        logic vpp_rom_12v;
        logic vpp_slot2_12v;
        logic vpp_slot1_12v;
    } bpgc_glue_t;

endpackage : bpgc_pkg

//--- rtl/bpgc_gp_pin.sv
/*
 * One general-purpose pin: plain output, address decode, or decode gated
 * with the I/O read or write command. Assumes bus inputs synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module bpgc_gp_pin (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire bpgc_pkg::bpgc_io_bus_t bus_in,
    input  wire logic [1:0]            mode_in,
    input  wire logic [7:0]            addr_idx_in,
    input  wire logic                  oe_in,
    input  wire logic                  level_in,
    output logic                       pin_out,
    output logic                       pin_oe_out
);
    import bpgc_pkg::*;

    logic hit;

    // ************************************************************
    // Decode.
    // ************************************************************

    // An index value names an eight-byte block: the address shifted down three places.
    function automatic logic block_hit(input logic [15:0] a, input logic [7:0] idx);
        block_hit = (a[15:10] == 6'h00) && (a[9:BLK_SHIFT] == idx[6:0]);
    endfunction : block_hit

    // The mode picks which qualifier reaches the pin.
    always_comb begin
        hit = block_hit(bus_in.addr, addr_idx_in);
        unique case (bpgc_gp_mode_t'(mode_in))
            GP_PLAIN_IO: pin_out = level_in;
            GP_DEC_IOR:  pin_out = hit & bus_in.ior;
            GP_DEC_IOW:  pin_out = hit & bus_in.iow;
            GP_DECODE:   pin_out = hit;
        endcase
    end

    // The pin drives only when enabled; otherwise it is an input.
    assign pin_oe_out = oe_in;

    property p_gated_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_in == GP_DEC_IOW) |-> (pin_out == (block_hit(bus_in.addr, addr_idx_in) && bus_in.iow));
    endproperty
    a_gated_write: assert property (p_gated_write) else $error("Write-gated decode wrong.");

    property p_plain_decode;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mode_in == GP_DECODE && bus_in.addr[15:10] == 6'h00 && bus_in.addr[9:3] == addr_idx_in[6:0])
        |-> pin_out;
    endproperty
    a_plain_decode: assert property (p_plain_decode) else $error("Plain decode missed a hit.");

endmodule : bpgc_gp_pin

`default_nettype wire

//--- rtl/bpgc_top.sv
/*
 * Board pin glue: configuration index registers, four general-purpose pins,
 * the write-only programming-voltage latch and five power control pins with
 * their board gates. Assumes an ISA-style I/O bus synchronous to ref_clk_in
 * and a power-management mode code supplied by the controller.
 */
`timescale 1ns/1ns
`default_nettype none

module bpgc_top (
    input  wire logic                   ref_clk_in,
    input  wire logic                   resetn_in,
    input  wire bpgc_pkg::bpgc_io_bus_t bus_in,
    input  wire logic [1:0]             pm_mode_in,
    input  wire logic                   system_reset_out_in,
    input  wire logic                   card_detect1_in,
    input  wire logic                   card_detect2_in,
    output logic [3:0]                  general_purpose_pin_out,
    output logic [3:0]                  general_purpose_pin_oe_out,
    output logic [4:0]                  power_control_pin_out,
    output bpgc_pkg::bpgc_glue_t        glue_out
);
    import bpgc_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [7:0]             idx_sel;
        logic [7:0]             oe_a;
        logic [7:0]             oe_b;
        logic [7:0]             gp_mode;
        logic [7:0]             gp_level;
        logic [NUM_GP-1:0][7:0] gp_addr;
        logic [7:0]             serial;
        logic [7:0]             serial_ovr;
        logic [7:0]             pm_slot1;
        logic [7:0]             pm_slot2;
        logic [7:0]             pm_kbd;
        logic [LATCH_W-1:0]     vpp_latch;
        logic                   strobe_q;
    } bpgc_state_t;

    localparam bpgc_state_t STATE_RESET = '{
        idx_sel: REG_RESET, oe_a: REG_RESET, oe_b: REG_RESET, gp_mode: REG_RESET,
        gp_level: REG_RESET, gp_addr: '0, serial: REG_RESET, serial_ovr: REG_RESET,
        pm_slot1: REG_RESET, pm_slot2: REG_RESET, pm_kbd: REG_RESET,
        vpp_latch: LATCH_RESET, strobe_q: 1'b0};

    bpgc_state_t      st;
    bpgc_state_t      next_st;
    logic             rst_meta;
    logic             rst_n;
    logic [3:0]       gp_pin;
    logic [3:0]       gp_oe;
    logic [3:0]       gp_oe_sel;
    logic             latch_strobe_net;
    logic             strobe_rise;
    logic             cfg_wr;
    logic [4:0]       pm_val;

    // ************************************************************
    // Reset release.
    // ************************************************************

    // Two flops so the release lands cleanly on a clock edge.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // General-purpose pins.
    // ************************************************************

    // Output enables sit in two indexes at scattered bit positions.
    assign gp_oe_sel = {st.oe_b[OE_BIT_SPARE], st.oe_b[OE_BIT_CS1], st.oe_b[OE_BIT_CS0],
                        st.oe_a[OE_BIT_STROBE]};

    // Each pin owns a two-bit field of the shared mode index.
    for (genvar g = 0; g < NUM_GP; g++) begin : g_pin
        bpgc_gp_pin bpgc_gp_pin_i (
            .clk_in      (ref_clk_in),
            .rst_n_in    (rst_n),
            .bus_in      (bus_in),
            .mode_in     (st.gp_mode[2*g +: 2]),
            .addr_idx_in (st.gp_addr[g]),
            .oe_in       (gp_oe_sel[g]),
            .level_in    (st.gp_level[g]),
            .pin_out     (gp_pin[g]),
            .pin_oe_out  (gp_oe[g])
        );
    end

    assign general_purpose_pin_out    = gp_pin;
    assign general_purpose_pin_oe_out = gp_oe;

    // The strobe net is the first pin only while it is actually driven.
    assign latch_strobe_net = gp_pin[0] & gp_oe[0];
    assign strobe_rise      = latch_strobe_net & ~st.strobe_q;
    assign cfg_wr           = bus_in.iow && (bus_in.addr == CFG_DATA_PORT);

    // ************************************************************
    // Next state.
    // ************************************************************

    // Index registers have no read path; software keeps its own shadow.
    always_comb begin
        next_st          = st;
        next_st.strobe_q = latch_strobe_net;
        if (bus_in.iow && bus_in.addr == CFG_INDEX_PORT) begin
            next_st.idx_sel = bus_in.data;
        end
        if (cfg_wr) begin
            unique case (st.idx_sel)
                IDX_OE_A:        next_st.oe_a       = bus_in.data;
                IDX_OE_B:        next_st.oe_b       = bus_in.data;
                IDX_SERIAL:      next_st.serial     = bus_in.data;
                IDX_SERIAL_OVR:  next_st.serial_ovr = bus_in.data;
                IDX_STROBE_ADDR: next_st.gp_addr[0] = bus_in.data;
                IDX_GP_MODE:     next_st.gp_mode    = bus_in.data;
                IDX_GP_LEVEL:    next_st.gp_level   = bus_in.data;
                IDX_CS0_ADDR:    next_st.gp_addr[1] = bus_in.data;
                IDX_CS1_ADDR:    next_st.gp_addr[2] = bus_in.data;
                IDX_SPARE_ADDR:  next_st.gp_addr[3] = bus_in.data;
                IDX_PM_SLOT1:    next_st.pm_slot1   = bus_in.data;
                IDX_PM_SLOT2:    next_st.pm_slot2   = bus_in.data;
                IDX_PM_KBD:      next_st.pm_kbd     = bus_in.data;
                default:         next_st.idx_sel    = st.idx_sel;
            endcase
        end
        // Only the low three data bits are stored; the rest are reserved.
        if (strobe_rise) begin
            next_st.vpp_latch = bus_in.data[LATCH_W-1:0];
        end
    end

    // All control state clears at reset, so the keyboard field starts at zero.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Power control pins and board glue.
    // ************************************************************

    // Picks the bit for the current power mode out of a four-bit field.
    function automatic logic mode_bit(input logic [3:0] nib, input logic [1:0] m);
        mode_bit = nib[m];
    endfunction : mode_bit

    // Every pin follows its per-mode value, except the serial pin while its override is enabled; slot 2 is the inverted one.
    always_comb begin
        pm_val[0] = mode_bit(st.pm_kbd[NIB_LO +: 4], pm_mode_in);
        pm_val[1] = mode_bit(st.pm_slot1[NIB_LO +: 4], pm_mode_in);
        pm_val[2] = st.serial_ovr[OVR_EN_BIT] ? st.serial_ovr[OVR_VAL_BIT]
                  : mode_bit(st.serial[NIB_LO +: 4], pm_mode_in);
        pm_val[3] = ~mode_bit(st.pm_slot2[NIB_LO +: 4], pm_mode_in);
        pm_val[4] = mode_bit(st.pm_slot1[NIB_HI +: 4], pm_mode_in);
    end

    assign power_control_pin_out = pm_val;

    // Board gates; the supply terms keep a card powered regardless of the pin.
    always_comb begin
        glue_out.kbd_reset       = system_reset_out_in | pm_val[0];
        glue_out.slot1_vcc       = ~pm_val[1] | card_detect1_in;
        glue_out.slot2_vcc       = ~pm_val[3] | card_detect2_in;
        glue_out.rs232_enable    = pm_val[2];
        glue_out.ir_select       = ~pm_val[2];
        glue_out.port2_tx_enable = pm_val[2];
        glue_out.vpp_rom_12v     = st.vpp_latch[LATCH_ROM_BIT];
        glue_out.vpp_slot2_12v   = st.vpp_latch[LATCH_S2_BIT];
        glue_out.vpp_slot1_12v   = st.vpp_latch[LATCH_S1_BIT];
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    property p_latch_capture;
        @(posedge ref_clk_in) disable iff (!rst_n)
        strobe_rise |=> (glue_out.vpp_rom_12v == $past(bus_in.data[2]))
                     && ({glue_out.vpp_slot2_12v, glue_out.vpp_slot1_12v} == $past(bus_in.data[1:0]));
    endproperty
    a_latch_capture: assert property (p_latch_capture) else $error("Latch missed strobe data.");

    property p_latch_hold;
        @(posedge ref_clk_in) disable iff (!rst_n)
        !strobe_rise |=> $stable(st.vpp_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch changed without strobe.");

    property p_strobe_range;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (st.gp_addr[0] == 8'h20 && st.gp_mode[1:0] == 2'b10 && st.oe_a[6] && bus_in.iow
         && bus_in.addr[15:3] == 13'h0020 && !st.strobe_q) |=> (st.vpp_latch == $past(bus_in.data[2:0]));
    endproperty
    a_strobe_range: assert property (p_strobe_range) else $error("Write to 100h-107h not latched.");

    property p_kbd_reset;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (system_reset_out_in || st.pm_kbd[pm_mode_in]) |-> glue_out.kbd_reset;
    endproperty
    a_kbd_reset: assert property (p_kbd_reset) else $error("Keyboard reset not asserted.");

    property p_kbd_reset_zero;
        @(posedge ref_clk_in) $rose(rst_n) |-> (st.pm_kbd[3:0] == 4'h0) && !power_control_pin_out[0];
    endproperty
    a_kbd_reset_zero: assert property (p_kbd_reset_zero) else $error("Keyboard field not zero.");

    property p_slot1;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (!power_control_pin_out[1] || card_detect1_in) |-> glue_out.slot1_vcc;
    endproperty
    a_slot1: assert property (p_slot1) else $error("Slot 1 supply wrongly off.");

    property p_slot2;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (power_control_pin_out[3] && !card_detect2_in) |-> !glue_out.slot2_vcc;
    endproperty
    a_slot2: assert property (p_slot2) else $error("Slot 2 supply wrongly on.");

    property p_serial;
        @(posedge ref_clk_in) disable iff (!rst_n)
        !power_control_pin_out[2] |-> glue_out.ir_select && !glue_out.port2_tx_enable && !glue_out.rs232_enable;
    endproperty
    a_serial: assert property (p_serial) else $error("Infrared mode not selected.");

    property p_slot2_invert;
        @(posedge ref_clk_in) disable iff (!rst_n)
        power_control_pin_out[3] == !st.pm_slot2[pm_mode_in];
    endproperty
    a_slot2_invert: assert property (p_slot2_invert) else $error("Slot 2 pin not inverted.");

endmodule : bpgc_top

`default_nettype wire

//--- tb/bpgc_board_model.sv
/*
 * Board-side partner of the pin glue block: two card slots and an IDE drive.
 * Assumes one clock shared with the block and the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module bpgc_board_model (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic card_insert1_in,
    input  wire logic card_insert2_in,
    input  wire logic drive_select0_in,
    input  wire logic drive_select1_in,
    output logic      card_detect1_out,
    output logic      card_detect2_out,
    output logic      drive_seen_out
);
    // ************************************************************
    // Card slots and drive.
    // ************************************************************
    // A slot reports a card only while one is inserted; no debounce is modelled.
    assign card_detect1_out = card_insert1_in;
    assign card_detect2_out = card_insert2_in;

    logic seen0;
    logic seen1;

    // Each select is remembered on its own, since the two decode ranges never overlap in time.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen0 <= 1'h0;
            seen1 <= 1'h0;
        end else begin
            seen0 <= seen0 | drive_select0_in;
            seen1 <= seen1 | drive_select1_in;
        end
    end

    // The drive reports success only once both selects have reached it.
    assign drive_seen_out = seen0 & seen1;
endmodule : bpgc_board_model

`default_nettype wire

//--- tb/bpgc_top_tb.sv
/*
 * Self-checking bench for the board pin glue block.
 * Assumes the package constants and a 100 MHz clock; inputs change at falling edges.
 */
`timescale 1ns/1ns
`default_nettype none

module bpgc_top_tb;
    import bpgc_pkg::*;

    typedef struct packed {
        logic [15:0] a;
        logic        w;
        logic        r;
        logic [3:0]  pins;
    } bpgc_row_t;

    logic         ref_clk_in;
    logic         resetn_in;
    logic         sys_rst;
    logic         ins1;
    logic         ins2;
    logic         cd1;
    logic         cd2;
    logic         seen;
    logic [1:0]   pm_mode;
    logic [3:0]   gp;
    logic [3:0]   gp_oe;
    logic [4:0]   pc;
    logic [4:0]   exp_pc;
    logic [7:0]   ac;
    logic [7:0]   aa;
    logic [7:0]   ab;
    logic [7:0]   ser;
    logic [7:0]   ov;
    logic         sp;
    bpgc_io_bus_t bus;
    bpgc_glue_t   glue;
    int           err_count;
    int           n_tests;

    // Decode table: pin 0 only on write, pins 1 and 2 on address alone.
    bpgc_row_t rows [10] = '{
        '{16'h0100, 1'h1, 1'h0, 4'h1}, '{16'h0107, 1'h1, 1'h0, 4'h1}, '{16'h0108, 1'h1, 1'h0, 4'h0},
        '{16'h0100, 1'h0, 1'h1, 4'h0}, '{16'h01F0, 1'h0, 1'h1, 4'h2}, '{16'h01F7, 1'h0, 1'h0, 4'h2},
        '{16'h01F8, 1'h0, 1'h1, 4'h0}, '{16'h03F0, 1'h0, 1'h1, 4'h4}, '{16'h03F7, 1'h1, 1'h0, 4'h4},
        '{16'h07F0, 1'h0, 1'h1, 4'h0}};

    bpgc_top bpgc_top_i (
        .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .bus_in(bus), .pm_mode_in(pm_mode),
        .system_reset_out_in(sys_rst), .card_detect1_in(cd1), .card_detect2_in(cd2),
        .general_purpose_pin_out(gp), .general_purpose_pin_oe_out(gp_oe),
        .power_control_pin_out(pc), .glue_out(glue));

    bpgc_board_model bpgc_board_model_i (
        .clk_in(ref_clk_in), .rst_n_in(resetn_in), .card_insert1_in(ins1), .card_insert2_in(ins2),
        .drive_select0_in(gp[1]), .drive_select1_in(gp[2]), .card_detect1_out(cd1),
        .card_detect2_out(cd2), .drive_seen_out(seen));

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // The command drops for a cycle after each write, so every latch write gives a fresh strobe edge.
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        bus.addr = a;
        bus.data = d;
        bus.iow = 1'h1;
        @(negedge ref_clk_in);
        bus.iow = 1'h0;
    endtask : io_wr

    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        io_wr(CFG_INDEX_PORT, idx);
        io_wr(CFG_DATA_PORT, val);
    endtask : cfg

    // Every power mode against every reset and card-detect combination.
    task automatic pm_sweep();
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 8; c++) begin
                @(negedge ref_clk_in);
                pm_mode = m[1:0];
                {sys_rst, ins1, ins2} = c[2:0];
                #1;
                sp = ov[0] ? ov[1] : ser[m];
                exp_pc = {aa[4 + m], ~ab[m], sp, aa[m], ac[m]};
                check({4'h0, pc}, {4'h0, exp_pc}, "power pins");
                check({3'h0, glue[8:3]}, {3'h0, sys_rst | ac[m], ~aa[m] | ins1, ab[m] | ins2, sp, ~sp, sp},
                      "glue gates");
            end
        end
    endtask : pm_sweep

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // ************************************************************
    // Clock, watchdog and tests.
    // ************************************************************
    initial begin
        ref_clk_in = 1'h0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // The tests need well under 2000 cycles; this bound only catches a hang.
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0;
        n_tests = 0;
        resetn_in = 1'h0;
        bus = '0;
        pm_mode = 2'h0;
        {sys_rst, ins1, ins2} = 3'h0;
        repeat (6) @(negedge ref_clk_in);
        check({5'h0, gp_oe}, 9'h000, "oe at reset");
        check({4'h0, pc}, 9'h008, "power pins at reset");
        check(glue, 9'h090, "glue at reset");
        resetn_in = 1'h1;
        repeat (3) @(negedge ref_clk_in);
        cfg(IDX_GP_MODE, 8'h3E);
        cfg(IDX_STROBE_ADDR, 8'h20);
        cfg(IDX_CS0_ADDR, 8'h3E);
        cfg(IDX_CS1_ADDR, 8'h7E);
        cfg(IDX_OE_A, 8'h40);
        cfg(IDX_OE_B, 8'h0C);
        cfg(8'h55, 8'hFF);
        check({5'h0, gp_oe}, 9'h007, "output enables");
        foreach (rows[i]) begin
            @(negedge ref_clk_in);
            bus.addr = rows[i].a;
            bus.iow = rows[i].w;
            bus.ior = rows[i].r;
            #1;
            check({5'h0, gp}, {5'h0, rows[i].pins}, "decode row");
        end
        @(negedge ref_clk_in);
        bus.iow = 1'h0;
        bus.ior = 1'h0;
        check({8'h0, seen}, 9'h001, "drive saw selects");
        // Spare pin: read-gated decode at 200h-207h, then a plain output level.
        cfg(IDX_SPARE_ADDR, 8'h40);
        cfg(IDX_OE_B, 8'h1C);
        cfg(IDX_GP_MODE, 8'h7E);
        @(negedge ref_clk_in);
        bus.addr = 16'h0203;
        bus.ior = 1'h1;
        #1;
        check({5'h0, gp}, 9'h008, "read-gated spare");
        check({5'h0, gp_oe}, 9'h00F, "spare enable");
        @(negedge ref_clk_in);
        bus.ior = 1'h0;
        #1;
        check({5'h0, gp}, 9'h000, "read-gated spare idle");
        cfg(IDX_GP_MODE, 8'h3E);
        cfg(IDX_GP_LEVEL, 8'h08);
        check({5'h0, gp}, 9'h008, "plain spare level");
        // Latch: reserved bits are dropped, writes outside the range are not taken.
        io_wr(LATCH_PORT, 8'hF5);
        check({6'h0, glue[2:0]}, 9'h005, "latch write");
        io_wr(16'h0104, 8'h02);
        check({6'h0, glue[2:0]}, 9'h002, "latch upper alias");
        io_wr(16'h0108, 8'h07);
        check({6'h0, glue[2:0]}, 9'h002, "latch outside range");
        // A write held high captures once; later data changes are not taken.
        @(negedge ref_clk_in);
        bus.addr = LATCH_PORT;
        bus.data = 8'h07;
        bus.iow = 1'h1;
        @(negedge ref_clk_in);
        bus.data = 8'h00;
        repeat (2) @(negedge ref_clk_in);
        check({6'h0, glue[2:0]}, 9'h007, "held write");
        bus.iow = 1'h0;
        ac = 8'h05;
        aa = 8'h93;
        ab = 8'h06;
        ser = 8'h0A;
        ov = 8'h00;
        cfg(IDX_PM_KBD, ac);
        cfg(IDX_PM_SLOT1, aa);
        cfg(IDX_PM_SLOT2, ab);
        cfg(IDX_SERIAL, ser);
        pm_sweep();
        ov = 8'h03;
        cfg(IDX_SERIAL_OVR, ov);
        pm_sweep();
        ov = 8'h01;
        cfg(IDX_SERIAL_OVR, ov);
        pm_sweep();
        // A reset in mid-cycle clears the latch at once, without a clock edge.
        @(negedge ref_clk_in);
        resetn_in = 1'h0;
        #1;
        check({6'h0, glue[2:0]}, 9'h000, "latch cleared by reset");
        check({5'h0, gp_oe}, 9'h000, "oe cleared by reset");
        repeat (3) @(negedge ref_clk_in);
        resetn_in = 1'h1;
        repeat (3) @(negedge ref_clk_in);
        check({4'h0, pc}, 9'h008, "power pins after reset");
        check({6'h0, glue[2:0]}, 9'h000, "latch after reset");
        check({5'h0, gp_oe}, 9'h000, "oe after reset");
        final_report();
    end
endmodule : bpgc_top_tb

`default_nettype wire
